/* inc/pcwd_cfg.svh */
// Constants for the polled control word decoder
`ifndef PCWD_CFG_SVH
`define PCWD_CFG_SVH
`define PCWD_WORDS          3'h4
`define PCWD_LAYOUT_SEL     8'h64
`define PCWD_BIT_FWD        0
`define PCWD_BIT_REV        1
`define PCWD_BIT_FRESET     2
`define PCWD_BIT_COAST      3
`define PCWD_BIT_NET_CTRL   5
`define PCWD_BIT_NET_REF    6
`define PCWD_FREQ_MAX       16'h8CA0
`define PCWD_ACC_MAX        16'h7530
`define PCWD_DEC_MAX        16'h7530
`define PCWD_FREQ_RST       16'h05DC
`define PCWD_ACC_RST        16'h0064
`define PCWD_DEC_RST        16'h0064
`define PCWD_SCAN_TIMEOUT_NS 1000000
`define PCWD_CLK_NS         4
`endif

/* inc/pcwd_pkg.sv */
// Types for the polled control word decoder
`default_nettype none
package pcwd_pkg;
  typedef struct packed {
    logic [15:0] w3;
    logic [15:0] w2;
    logic [15:0] w1;
    logic [15:0] w0;
  } pcwd_image_s;
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] acc;
    logic [15:0] dec;
  } pcwd_profile_s;
  typedef struct packed {
    logic forward_run_flag;
    logic reverse_run_flag;
    logic fault_reset;
    logic coast;
  } pcwd_cmd_s;
endpackage : pcwd_pkg
`default_nettype wire

/* hw/pcwd_decoder.sv */
// Polled control word decoder for the network drive interface
// Functional notes
// - Command image is four 16-bit words.
// - Low byte of word 0 is flags; words 1 to 3 are unsigned values.
// - Layout applies only when layout selection equals 100.
// - Frequency override is bytes 2 (low) and 3 (high).
// - Accel override bytes 4,5; decel bytes 6,7; low byte first.
// - Bit 0 runs forward, bit 1 reverse, both clear stops.
// - Bit 2 set resets drive and clears trip; zero does nothing.
// - Bit 3 set makes motor coast to stop; zero does nothing.
// - Bit 5 selects run/stop source: zero local, one network.
// - Bit 6 selects profile source: zero stored, one words 1 to 3.
// - Network command source turns off the run key indicator.
// - Command and profile sources are selected independently.
// - Enable inactive forces both command and profile local.
// - Source switching never raises a communication error.
// - A fresh image is taken on every network scan.
// - Source-select changes are ignored while the drive runs.
// - Lost scan or connection returns control to local.
// - Out-of-range override values are discarded.
// - Frequency override is in hundredths of a hertz.
`include "pcwd_cfg.svh"
`default_nettype none
module pcwd_decoder
  import pcwd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC =
    (`PCWD_SCAN_TIMEOUT_NS) / (`PCWD_CLK_NS)
) (
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  input  wire logic          scan_valid_i,
  input  wire pcwd_image_s   scan_image_i,
  input  wire logic          conn_active_i,
  input  wire logic [7:0]    layout_sel_i,
  input  wire logic          net_enable_i,
  input  wire logic          term_assigned_i,
  input  wire logic          network_select_terminal_i,
  input  wire pcwd_cmd_s     local_cmd_i,
  input  wire pcwd_profile_s stored_profile_i,
  input  wire logic          drive_running_i,
  output logic               cmd_from_net_o,
  output logic               prof_from_net_o,
  output logic               run_key_led_o,
  output logic               comm_error_o,
  output pcwd_cmd_s          cmd_o,
  output pcwd_profile_s      profile_o
);
  // Refuse a watchdog span too short to see one scan
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("TIMEOUT_CYC too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser for the select terminal
  logic [2:0] term_sync;
  logic       term_level;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) term_sync <= 3'h0;
    else         term_sync <= {term_sync[1:0], network_select_terminal_i};
  end
  // Level accepted only when the last two stages agree
  always_ff @(posedge core_clk_i) begin
    if (reset_i) term_level <= 1'b0;
    else if (term_sync[2] == term_sync[1]) term_level <= term_sync[2];
  end

  // Range check shared by the three overrides
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lim);
    in_range = (v <= lim);
  endfunction : in_range

  ////////////////////////////////////////////////////////////////////////
  // Scan watchdog
  logic [31:0] scan_age;
  logic        scan_alive;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      scan_age   <= 32'h0;
      scan_alive <= 1'b0;
    end else if (scan_valid_i && conn_active_i) begin
      scan_age   <= 32'h0;
      scan_alive <= 1'b1;
    end else if (!conn_active_i || scan_age >= TIMEOUT_CYC - 1) begin
      scan_alive <= 1'b0; // Lost scan or connection
    end else begin
      scan_age <= scan_age + 32'h1;
    end
  end

  wire logic layout_ok = (layout_sel_i == `PCWD_LAYOUT_SEL);
  wire logic take = scan_valid_i && conn_active_i && layout_ok;
  // Enable source: terminal overrides setting when assigned
  wire logic net_en = term_assigned_i ? term_level : net_enable_i;
  wire logic net_ok = net_en && scan_alive && layout_ok;

  ////////////////////////////////////////////////////////////////////////
  // Latched image, refreshed every scan
  logic [7:0]    ctrl;    // Byte 1 is dropped
  pcwd_profile_s net_prof;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) ctrl <= 8'h00;
    else if (take) ctrl <= scan_image_i.w0[7:0]; // Flags byte
  end
  // Overrides, little-endian words, discarded if out of range
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      net_prof.freq <= `PCWD_FREQ_RST;
      net_prof.acc  <= `PCWD_ACC_RST;
      net_prof.dec  <= `PCWD_DEC_RST;
    end else if (take) begin
      // Word 1, 0.01 Hz units
      if (in_range(scan_image_i.w1, `PCWD_FREQ_MAX))
        net_prof.freq <= scan_image_i.w1;
      if (in_range(scan_image_i.w2, `PCWD_ACC_MAX))
        net_prof.acc <= scan_image_i.w2;
      if (in_range(scan_image_i.w3, `PCWD_DEC_MAX))
        net_prof.dec <= scan_image_i.w3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source selects, frozen while running
  logic sel_ctrl;
  logic sel_ref;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sel_ctrl <= 1'b0;
      sel_ref  <= 1'b0;
    end else if (!net_ok) begin
      sel_ctrl <= 1'b0; // Fall back to local
      sel_ref  <= 1'b0;
    end else if (!drive_running_i) begin
      sel_ctrl <= ctrl[`PCWD_BIT_NET_CTRL];
      sel_ref  <= ctrl[`PCWD_BIT_NET_REF];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cmd_from_net_o  <= 1'b0;
      prof_from_net_o <= 1'b0;
      run_key_led_o   <= 1'b1;
    end else begin
      cmd_from_net_o  <= sel_ctrl && net_ok;
      prof_from_net_o <= sel_ref && net_ok;
      run_key_led_o   <= !(sel_ctrl && net_ok);
    end
  end
  // Command mux: net bits or local command
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cmd_o <= '0;
    end else if (sel_ctrl && net_ok) begin
      cmd_o.forward_run_flag <= ctrl[`PCWD_BIT_FWD];
      cmd_o.reverse_run_flag <= ctrl[`PCWD_BIT_REV];
      cmd_o.fault_reset <= ctrl[`PCWD_BIT_FRESET];
      cmd_o.coast       <= ctrl[`PCWD_BIT_COAST];
    end else begin
      cmd_o <= local_cmd_i;
    end
  end
  // Profile mux
  always_ff @(posedge core_clk_i) begin
    if (reset_i) profile_o <= '0;
    else profile_o <= (sel_ref && net_ok) ? net_prof : stored_profile_i;
  end
  // Switching never flags a communication fault
  always_ff @(posedge core_clk_i) begin
    if (reset_i) comm_error_o <= 1'b0;
    else         comm_error_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb_core @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // Indicator and command source agree
  a_led_follows_src: assert property (
    cmd_from_net_o |-> !run_key_led_o)
    else $error("run key indicator on under network control");
  // Network flag bits land in the command struct
  a_fwd_cmd_map: assert property (
    (sel_ctrl && net_ok) |=> cmd_o.forward_run_flag == $past(ctrl[0]))
    else $error("forward command not from bit 0");
  a_rev_cmd_map: assert property (
    (sel_ctrl && net_ok) |=> cmd_o.reverse_run_flag == $past(ctrl[1]))
    else $error("reverse command not from bit 1");
  a_reset_bit_map: assert property (
    (sel_ctrl && net_ok) |=> cmd_o.fault_reset == $past(ctrl[2]))
    else $error("fault reset not from bit 2");
  a_coast_bit_map: assert property (
    (sel_ctrl && net_ok) |=> cmd_o.coast == $past(ctrl[3]))
    else $error("coast not from bit 3");
  // Local command passes through when the network does not own it
  a_cmd_local: assert property (
    !(sel_ctrl && net_ok) |=> cmd_o == $past(local_cmd_i))
    else $error("local command not passed through");
  // Profile taken from the latched overrides when selected
  a_prof_src_map: assert property (
    (sel_ref && net_ok) |=> profile_o == $past(net_prof))
    else $error("profile not from network overrides");
  // Selects frozen while the drive runs
  a_sel_hold_run: assert property (
    (drive_running_i && net_ok) |=> $stable(sel_ctrl))
    else $error("command select changed while running");
  a_ref_hold_run: assert property (
    (drive_running_i && net_ok) |=> $stable(sel_ref))
    else $error("profile select changed while running");
  // Fallback to local sources
  a_local_no_enable: assert property (
    !net_ok |=> !sel_ctrl && !sel_ref)
    else $error("network source kept without enable");
  // Latched overrides never exceed their limits
  a_freq_range: assert property (
    net_prof.freq <= `PCWD_FREQ_MAX)
    else $error("frequency override out of range");
  a_acc_range: assert property (
    net_prof.acc <= `PCWD_ACC_MAX)
    else $error("acceleration override out of range");
  a_dec_range: assert property (
    net_prof.dec <= `PCWD_DEC_MAX)
    else $error("deceleration override out of range");
  // No error flag around a source switch
  a_no_comm_err: assert property (
    $changed(sel_ctrl) |-> !comm_error_o [*3])
    else $error("communication error on source switch");
  // Foreign layouts leave the control byte alone
  a_layout_gate: assert property (
    !layout_ok |=> $stable(ctrl))
    else $error("image taken under wrong layout");
  // Main scenarios
  c_net_run: cover property (cmd_from_net_o && cmd_o.forward_run_flag);
  c_split_src: cover property (cmd_from_net_o && !prof_from_net_o);
  c_net_prof: cover property (prof_from_net_o);
  c_sel_frozen: cover property (drive_running_i && sel_ctrl && net_ok);
endmodule : pcwd_decoder
`default_nettype wire

/* testbench/pcwd_master.sv */
// Network master model that scans the command image cyclically
`default_nettype none
module pcwd_master
  import pcwd_pkg::*;
#(
  parameter int unsigned PERIOD = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire pcwd_image_s img_i,
  output logic             valid_o,
  output pcwd_image_s      image_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  ////////////////////////////////////////////////////////////////////
  // One four-word image per scan; between scans the lines keep toggling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt     <= 8'h00;
      valid_o <= 1'b0;
      image_o <= '0;
    end else begin
      cnt     <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
      valid_o <= run_i && (cnt == 8'h00);
      image_o <= (run_i && cnt == 8'h00) ? img_i : ~image_o;
    end
  end
endmodule : pcwd_master
`default_nettype wire

/* testbench/polled_control_word_decoder_tb.sv */
// Self-checking bench for the polled control word decoder
`default_nettype none
module polled_control_word_decoder_tb;
  import pcwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, drv_run = 1'b0;
  logic net_en = 1'b1, tas = 1'b0, nst = 1'b0, conn = 1'b0, sv;
  logic [7:0] lay = 8'h64;
  pcwd_image_s img = '0, si;
  pcwd_cmd_s loc = 4'b0001, cmd;
  pcwd_profile_s sto = {16'h05DC, 16'h0064, 16'h0064}, prof;
  logic cn, pn, led, cerr;
  int err_total = 0, n_compared = 0;
  // Clock at 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end
  pcwd_master #(.PERIOD(8)) mst_u (.clk_i(clk), .rst_i(rst), .run_i(run),
    .img_i(img), .valid_o(sv), .image_o(si));
  pcwd_decoder #(.TIMEOUT_CYC(64)) dut_u (.core_clk_i(clk), .reset_i(rst),
    .scan_valid_i(sv), .scan_image_i(si), .conn_active_i(conn),
    .layout_sel_i(lay), .net_enable_i(net_en), .term_assigned_i(tas),
    .network_select_terminal_i(nst), .local_cmd_i(loc),
    .stored_profile_i(sto), .drive_running_i(drv_run),
    .cmd_from_net_o(cn), .prof_from_net_o(pn), .run_key_led_o(led),
    .comm_error_o(cerr), .cmd_o(cmd), .profile_o(prof));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] e, g);
    n_compared++;
    if (e !== g) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Compare every output of the decoder
  task automatic look(input logic c, p, l, input logic [3:0] k,
                      input logic [47:0] f);
    chk("cmd_from_net", 48'(c), 48'(cn));
    chk("prof_from_net", 48'(p), 48'(pn));
    chk("run_key_led", 48'(l), 48'(led));
    chk("comm_error", 48'h0, 48'(cerr));
    chk("cmd", 48'(k), 48'(cmd));
    chk("profile", f, prof);
  endtask : look
  // Load a new image into the master and let several scans pass
  task automatic scen(input logic [15:0] w0, w1, w2, w3);
    @(posedge clk);
    img <= {w3, w2, w1, w0};
    repeat (30) @(posedge clk);
    #1;
  endtask : scen
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    #20000;
    err_total++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (9) @(posedge clk);
    #1;
    look(0, 0, 1, 4'h0, 48'h0);
    @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    conn <= 1'b1;
    scen(16'h0021, 16'h07D0, 16'h0064, 16'h0064);
    look(1, 0, 0, 4'b1000, sto);
    scen(16'hFFFE, 16'h07D0, 16'h1234, 16'h0ABC);
    look(1, 1, 0, 4'b0111, 48'h07D0_1234_0ABC);
    chk("freq", 48'h07D0, 48'(prof.freq));
    chk("accel", 48'h1234, 48'(prof.acc));
    scen(16'h0060, 16'h8CA1, 16'h7531, 16'h0001);
    look(1, 1, 0, 4'h0, 48'h07D0_1234_0001);
    // Selects must hold while running although the bits drop
    @(posedge clk);
    drv_run <= 1'b1;
    scen(16'h0000, 16'h07D0, 16'h1234, 16'h0001);
    look(1, 1, 0, 4'h0, 48'h07D0_1234_0001);
    // Foreign layout: image ignored and control falls back to local
    @(posedge clk);
    drv_run <= 1'b0;
    lay <= 8'h65;
    scen(16'h0021, 16'h0100, 16'h0100, 16'h0100);
    look(0, 0, 1, 4'b0001, sto);
    @(posedge clk);
    lay <= 8'h64;
    net_en <= 1'b0;
    scen(16'h0061, 16'h07D0, 16'h1234, 16'h0001);
    look(0, 0, 1, 4'b0001, sto);
    @(posedge clk);
    tas <= 1'b1;
    nst <= 1'b1;
    scen(16'h0061, 16'h07D0, 16'h1234, 16'h0001);
    look(1, 1, 0, 4'b1000, 48'h07D0_1234_0001);
    // Scans stop with the connection still up: watchdog expires
    @(posedge clk);
    run <= 1'b0;
    repeat (100) @(posedge clk);
    #1;
    look(0, 0, 1, 4'b0001, sto);
    @(posedge clk);
    run <= 1'b1;
    scen(16'h0061, 16'h07D0, 16'h1234, 16'h0001);
    look(1, 1, 0, 4'b1000, 48'h07D0_1234_0001);
    // Connection drops while scans continue
    @(posedge clk);
    conn <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    look(0, 0, 1, 4'b0001, sto);
    summarize();
  end
endmodule : polled_control_word_decoder_tb
`default_nettype wire
